// File: rtl/ecip_map.vh
// How it works
// (RULE1) external source: one measurement per falling edge of the trigger line; the code starts none for edges during a load or calibration
// (RULE2) internal source: trigger edges start no measurement
// (RULE3) trigger edges still reach statistics, memory and value output
// (RULE4) seven select lines form panel number, bit0 lsb, sampled at trigger
// (RULE5) a select bit is one when its line is low
// (RULE6) same code as last trigger: no load, plain measurement in external mode
// (RULE7) code all zeros or all ones: no panel load
// (RULE8) allow at least 70 ms after a load starts before settings apply
// (RULE9) external mode: one measurement once a trigger load completes
// (RULE10) manual calibration at fast or medium rate starts on calibration edge; the code starts it only when idle and with no trigger edge that cycle
// (RULE11) slow rate: calibration line ignored entirely
// (RULE12) calibration lasts about 176 ms at 50 Hz, 151 ms at 60 Hz
// (RULE13) all lines active low; edge inputs act on falling edges, others on level
// (RULE14) one zero adjustment per falling edge of the zero-adjust line
// (RULE15) one print per falling edge of the print line
// (RULE16) manual comparator mode: judgment enabled only while manual line low
// (RULE17) every input synchronised before edge detection, one pulse per edge
// (RULE18) last captured code kept for comparison, cleared at reset
`ifndef ECIP_MAP_VH
`define ECIP_MAP_VH
`define ECIP_CLK_MHZ 100
`define ECIP_LOAD_MS 70
`define ECIP_CAL50_MS 176
`define ECIP_CAL60_MS 151
`define ECIP_LOAD_CYC (`ECIP_LOAD_MS * `ECIP_CLK_MHZ * 1000)
`define ECIP_CAL50_CYC (`ECIP_CAL50_MS * `ECIP_CLK_MHZ * 1000)
`define ECIP_CAL60_CYC (`ECIP_CAL60_MS * `ECIP_CLK_MHZ * 1000)
`define ECIP_RATE_FAST 2'h0
`define ECIP_RATE_MED 2'h1
`define ECIP_RATE_SLOW 2'h2
`define ECIP_CODE_NONE 7'h00
`define ECIP_CODE_ALL 7'h7f
`define ECIP_SYNC_RST 1'b1
`endif

// File: rtl/ecip_sync.v
`timescale 1ns/1ps
`include "ecip_map.vh"
module ecip_sync #(
  parameter W = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] d_n_i,
  output reg [W-1:0] q_n_o
);
  // two flops; first stage read only by the second
  reg [W-1:0] meta_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{`ECIP_SYNC_RST}};
      q_n_o <= {W{`ECIP_SYNC_RST}};
    end else if (ce_i) begin
      meta_r <= d_n_i; // see (RULE17)
      q_n_o <= meta_r;
    end
  end
endmodule

// File: rtl/ecip_top.v
// The register addresses and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`include "ecip_map.vh"
module ecip_top #(
  parameter LOAD_CYC = `ECIP_LOAD_CYC,
  parameter CAL50_CYC = `ECIP_CAL50_CYC,
  parameter CAL60_CYC = `ECIP_CAL60_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_measure_request_n_i,
  input wire [6:0] panel_sel_n_i,
  input wire offset_null_request_n_i,
  input wire cal_request_n_i,
  input wire print_request_n_i,
  input wire manual_judge_n_i,
  input wire core_busy_i,
  output reg measure_start_o,
  output reg ext_measure_request_n_event_o,
  output reg panel_load_o,
  output reg [6:0] panel_num_o,
  output reg settings_apply_o,
  output reg cal_start_o,
  output reg cal_busy_o,
  output reg zero_adj_o,
  output reg print_o,
  output reg judge_en_o
);
  // register map: word offsets (byte address = index * 4)
  localparam [3:0] A_CTRL = 4'h0;
  localparam [3:0] A_STAT = 4'h1;
  localparam [3:0] A_LAST = 4'h2;

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_LOAD = 2'h1;
  localparam [1:0] S_CAL = 2'h2;

  // ctrl: [0] ext trigger, [2:1] rate, [3] manual cal, [4] 60 Hz, [5] manual comparator
  reg ext_src_r;
  reg [1:0] rate_r;
  reg man_cal_r;
  reg hz60_r;
  reg man_cmp_r;
  reg [6:0] last_code_r;
  reg [1:0] state_r;
  reg [31:0] cnt_r;
  reg [7:0] ext_measure_request_n_cnt_r;

  wire [11:0] sync_n;
  ecip_sync #(.W(12)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_n_i({manual_judge_n_i, print_request_n_i, cal_request_n_i,
            offset_null_request_n_i, ext_measure_request_n_i, panel_sel_n_i}),
    .q_n_o(sync_n)
  );

  reg [3:0] prev_n_r;
  wire [3:0] edge_w = prev_n_r & ~sync_n[10:7]; // see (RULE13) (RULE17)
  wire ext_measure_request_n_w = edge_w[0];
  wire zadj_w = edge_w[1];
  wire cal_w = edge_w[2];
  wire prn_w = edge_w[3];
  wire [6:0] code_w = ~sync_n[6:0]; // see (RULE5) (RULE4)

  function loadable;
    input [6:0] c;
    input [6:0] prev;
    begin
      loadable = (c != `ECIP_CODE_NONE) && (c != `ECIP_CODE_ALL) && (c != prev);
    end
  endfunction

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire cal_ok = man_cal_r && (rate_r != `ECIP_RATE_SLOW); // see (RULE11)
  wire [31:0] cal_len = hz60_r ? CAL60_CYC : CAL50_CYC; // see (RULE12)

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_n_r <= 4'hf;
      ext_src_r <= 1'b0;
      rate_r <= `ECIP_RATE_SLOW;
      man_cal_r <= 1'b0;
      hz60_r <= 1'b0;
      man_cmp_r <= 1'b0;
      last_code_r <= 7'h00; // see (RULE18)
      state_r <= S_IDLE;
      cnt_r <= 32'h0;
      ext_measure_request_n_cnt_r <= 8'h00;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
      measure_start_o <= 1'b0;
      ext_measure_request_n_event_o <= 1'b0;
      panel_load_o <= 1'b0;
      panel_num_o <= 7'h00;
      settings_apply_o <= 1'b0;
      cal_start_o <= 1'b0;
      cal_busy_o <= 1'b0;
      zero_adj_o <= 1'b0;
      print_o <= 1'b0;
      judge_en_o <= 1'b0;
    end else if (ce_i) begin
      prev_n_r <= sync_n[10:7];
      measure_start_o <= 1'b0;
      ext_measure_request_n_event_o <= ext_measure_request_n_w; // see (RULE3)
      panel_load_o <= 1'b0;
      settings_apply_o <= 1'b0;
      cal_start_o <= 1'b0;
      zero_adj_o <= zadj_w; // see (RULE14)
      print_o <= prn_w; // see (RULE15)
      judge_en_o <= man_cmp_r ? !sync_n[11] : 1'b1; // see (RULE16)
      wb_ack_o <= wb_req;
      // write lands on the edge where the master sees ack, not on the request edge
      if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == A_CTRL && wb_sel_i[0]) begin
        ext_src_r <= wb_dat_i[0];
        rate_r <= wb_dat_i[2:1];
        man_cal_r <= wb_dat_i[3];
        hz60_r <= wb_dat_i[4];
        man_cmp_r <= wb_dat_i[5];
      end
      if (wb_req) begin
        case (wb_adr_i)
          A_CTRL: wb_dat_o <= {26'h0, man_cmp_r, hz60_r, man_cal_r, rate_r, ext_src_r};
          A_STAT: wb_dat_o <= {22'h0, ext_measure_request_n_cnt_r, state_r};
          A_LAST: wb_dat_o <= {25'h0, last_code_r};
          default: wb_dat_o <= 32'h0;
        endcase
      end
      if (ext_measure_request_n_w) begin
        ext_measure_request_n_cnt_r <= ext_measure_request_n_cnt_r + 8'h01;
      end
      case (state_r)
        S_IDLE: begin
          if (ext_measure_request_n_w) begin
            last_code_r <= code_w; // see (RULE4) (RULE18)
            if (loadable(code_w, last_code_r)) begin // see (RULE6) (RULE7)
              panel_load_o <= 1'b1;
              panel_num_o <= code_w;
              cnt_r <= LOAD_CYC;
              state_r <= S_LOAD;
            end else if (ext_src_r) begin
              measure_start_o <= 1'b1; // see (RULE1) (RULE2) (RULE6)
            end
          end else if (cal_w && cal_ok) begin
            cal_start_o <= 1'b1; // see (RULE10)
            cal_busy_o <= 1'b1;
            cnt_r <= cal_len;
            state_r <= S_CAL;
          end
        end
        S_LOAD: begin
          // load must outlast both the floor and the core's own settle time
          if (cnt_r > 32'h1) begin
            cnt_r <= cnt_r - 32'h1; // see (RULE8)
          end else if (!core_busy_i) begin
            settings_apply_o <= 1'b1;
            measure_start_o <= ext_src_r; // see (RULE9)
            state_r <= S_IDLE;
          end
        end
        S_CAL: begin
          if (cnt_r > 32'h1) begin
            cnt_r <= cnt_r - 32'h1; // see (RULE12)
          end else begin
            cal_busy_o <= 1'b0;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// File: testbench/ecip_ctrl_model.sv
`timescale 1ns/1ps
module ecip_ctrl_model (
  input wire clk_i,
  output reg [3:0] edge_n_o = 4'hf,
  output reg [6:0] panel_sel_n_o = 7'h7f,
  output reg manual_judge_n_o = 1'b1
);
  // code settles before the edge; a one bit pulls its line low
  task strike(input integer k, input [6:0] code);
    begin
      panel_sel_n_o <= ~code;
      repeat (3) @(posedge clk_i);
      edge_n_o[k] <= 1'b0;
      repeat (4) @(posedge clk_i);
      edge_n_o[k] <= 1'b1;
    end
  endtask
endmodule

// File: testbench/ecip_top_properties.sv
`timescale 1ns/1ps
module ecip_top_properties #(parameter LOAD_CYC = 20) (
  input wire clk_i, input wire rst_i, input wire wb_cyc_i, input wire wb_stb_i,
  input wire wb_ack_o, input wire ext_measure_request_n_i, input wire ext_measure_request_n_event_o,
  input wire panel_load_o, input wire [6:0] panel_num_o, input wire settings_apply_o,
  input wire cal_start_o, input wire cal_busy_o
);
  reg [31:0] gap_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycles since a load began, so an early apply shows
  always @(posedge clk_i) gap_r <= (rst_i || panel_load_o) ? 32'h0 : gap_r + 32'h1;
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack");
  ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack drop");
  ext_measure_request_n_pulse_a:
    assert property ($fell(ext_measure_request_n_i) |-> ##[2:4] ext_measure_request_n_event_o) else $error("ext_measure_request_n");
  ext_measure_request_n_once_a: assert property (ext_measure_request_n_event_o |=> !ext_measure_request_n_event_o) else $error("twice");
  load_code_a:
    assert property (panel_load_o |-> !(panel_num_o inside {7'h00, 7'h7f})) else $error("code");
  apply_wait_a:
    assert property (settings_apply_o |-> gap_r >= LOAD_CYC - 1) else $error("early");
  cal_hold_a: assert property (cal_start_o |=> cal_busy_o [*8]) else $error("cal");
  num_hold_a: assert property ($changed(panel_num_o) |-> panel_load_o) else $error("num");
  cover property (panel_load_o);
  cover property (settings_apply_o);
  cover property (cal_start_o);
endmodule
bind ecip_top ecip_top_properties #(.LOAD_CYC(LOAD_CYC)) u_ecip_top_properties (.*);

// File: testbench/ecip_top_tb.sv
`timescale 1ns/1ps
module ecip_top_tb;
  localparam LOAD = 20;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [3:0] wb_adr_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg [31:0] q;
  wire [31:0] wb_dat_o;
  wire [6:0] panel_sel_n_i, panel_num_o;
  wire wb_ack_o, ext_measure_request_n_i, offset_null_request_n_i, cal_request_n_i;
  wire print_request_n_i, manual_judge_n_i, measure_start_o, ext_measure_request_n_event_o, panel_load_o;
  wire settings_apply_o, cal_start_o, cal_busy_o, zero_adj_o, print_o, judge_en_o;
  wire [6:0] ev = {print_o, zero_adj_o, cal_start_o, settings_apply_o, panel_load_o,
    ext_measure_request_n_event_o, measure_start_o};
  integer failures = 0, checked = 0;
  integer n [0:6] = '{default: 0};
  integer b [0:6];
  ecip_ctrl_model u_ecip_ctrl_model (.clk_i(clk_i), .edge_n_o({print_request_n_i,
    cal_request_n_i, offset_null_request_n_i, ext_measure_request_n_i}),
    .panel_sel_n_o(panel_sel_n_i), .manual_judge_n_o(manual_judge_n_i));
  ecip_top #(.LOAD_CYC(LOAD), .CAL50_CYC(LOAD), .CAL60_CYC(LOAD)) u_ecip_top (.ce_i(1'b1),
    .wb_stb_i(wb_cyc_i), .wb_sel_i(4'hf), .core_busy_i(1'b0), .*);
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) for (int i = 0; i < 7; i++) n[i] <= n[i] + ev[i];
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checked++;
      if (seen !== exp) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      if (failures == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task wb(input w, input [3:0] a, input [31:0] d);
    integer t;
    begin
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      t = 0;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++t < 50);
      if (wb_ack_o !== 1'b1) failures++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  // the wait outlasts a full load, so every pulse of one trigger is counted
  task hit(input integer k, input [6:0] code);
    begin
      b = n;
      u_ecip_ctrl_model.strike(k, code);
      repeat (LOAD + 12) @(posedge clk_i);
    end
  endtask
  function integer d(input integer i);
    d = n[i] - b[i];
  endfunction
  task t_regs;
    begin
      wb(0, 4'h0, 32'h0);
      chk("ctrl", q, 32'h4);
      wb(1, 4'hf, 32'hffffffff);
      wb(0, 4'hf, 32'h0);
      chk("hole", q, 32'h0);
    end
  endtask
  task t_ext_measure_request_n;
    begin
      hit(0, 7'h05);
      chk("int_meas", d(0), 0);
      chk("int_evt", d(1), 1);
      wb(1, 4'h0, 32'h1);
      hit(0, 7'h05);
      chk("same", d(2) * 10 + d(0), 1);
      hit(0, 7'h7e);
      chk("num", panel_num_o, 7'h7e);
      chk("load", d(2) * 100 + d(3) * 10 + d(0), 111);
      hit(0, 7'h7f);
      chk("ones", d(2), 0);
      hit(0, 7'h00);
      chk("zeros", d(2) * 10 + d(0), 1);
    end
  endtask
  task t_cal;
    begin
      for (int r = 0; r < 3; r++) begin
        wb(1, 4'h0, 32'h8 | (r << 1) | ((r & 1) << 4));
        hit(2, 7'h00);
        chk("cal", d(4), r != 2);
      end
    end
  endtask
  task t_misc;
    begin
      hit(1, 7'h00);
      chk("zero", d(5), 1);
      hit(3, 7'h00);
      chk("print", d(6), 1);
      wb(1, 4'h0, 32'h20);
      repeat (8) @(posedge clk_i);
      chk("judge_off", judge_en_o, 0);
      u_ecip_ctrl_model.manual_judge_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk("judge_on", judge_en_o, 1);
    end
  endtask
  initial begin
    #200000;
    failures++;
    conclude;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_ext_measure_request_n;
    t_cal;
    t_misc;
    conclude;
  end
endmodule
